// ### mm_range_pkg.sv
// package of constants and types for the multimeter mode and range control
package mm_range_pkg;

    // ************************************************************
    // measuring modes
    // ************************************************************
    localparam logic [7:0] MODE_DC_VOLT  = 8'h00;
    localparam logic [7:0] MODE_AC_VOLT  = 8'h01;
    localparam logic [7:0] MODE_DC_CURR  = 8'h02;
    localparam logic [7:0] MODE_AC_CURR  = 8'h03;
    localparam logic [7:0] MODE_RESET    = MODE_DC_VOLT;

    // ************************************************************
    // measuring ranges (power of ten codes)
    // ************************************************************
    localparam logic [7:0] RANGE_300MV   = 8'hFF;
    localparam logic [7:0] RANGE_3V      = 8'h00;
    localparam logic [7:0] RANGE_30V     = 8'h01;
    localparam logic [7:0] RANGE_300V    = 8'h02;
    localparam logic [7:0] RANGE_RESET   = RANGE_300MV;

    // ************************************************************
    // autorange decision
    // ************************************************************
    localparam int         STABLE_COUNT  = 8;
    localparam logic [3:0] STABLE_RESET  = 4'h0;
    localparam logic [31:0] VALUE_RESET  = 32'h0000_0000;

    // cyclic control data from the master
    typedef struct packed {
        logic       disable_auto_ranging_flag;
        logic [7:0] control_mode_field;
        logic [7:0] control_range_field;
    } cyclic_control_t;

    // measured sample offered by the converter
    typedef struct packed {
        logic        valid;
        logic [7:0]  range;
        logic [31:0] value;
    } sample_t;

endpackage : mm_range_pkg

// ### range_stability.sv
// counter of successive samples that fall in one measuring range
module range_stability
    import mm_range_pkg::*;
#(
    parameter int NEEDED = STABLE_COUNT
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // samples
    input  wire logic       sample_valid,
    input  wire logic [7:0] sample_range,
    input  wire logic       restart,
    // decision
    output logic            stable,
    output logic [7:0]      stable_range
);

    logic [3:0] count_q;
    logic [7:0] last_q;

    // ************************************************************
    // run counter
    // ************************************************************
    // the counter saturates so a steady input keeps deciding every sample
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_q <= STABLE_RESET;
            last_q  <= RANGE_RESET;
        end else if (restart) begin
            count_q <= STABLE_RESET;
        end else if (sample_valid) begin
            last_q <= sample_range;
            if (count_q == 4'h0 || sample_range != last_q) begin
                count_q <= 4'h1;
            end else if (count_q < 4'(NEEDED)) begin
                count_q <= count_q + 4'h1;
            end
        end
    end

    assign stable       = (count_q == 4'(NEEDED));
    assign stable_range = last_q;

endmodule : range_stability

// ### mm_range_ctrl.sv
// mode selection, autorange decision and measured value hold of the multimeter
// Behaviour
// RL1: after reset measure DC voltage, mode 0, with autorange active
// RL2: disable flag true makes the control range field the effective range
// RL3: master drops cyclic control before configuring through parameters
// RL4: control mode field value 0 selects DC voltage measurement
// RL5: scaled value is signed 32 bit, one step per microvolt or microampere
// RL6: report the range in effect; code 1 means 30 V / 10 A
// RL7: autorange commits only after eight successive samples in one range
// RL8: without an autorange decision hold value and keep update toggle
// RL9: master should fix the range itself for rapidly changing inputs
// RL10: with disable flag false the control range field is ignored
module mm_range_ctrl
    import mm_range_pkg::*;
#(
    parameter int NEEDED = STABLE_COUNT
) (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            rstn,
    // cyclic control from the master
    input  wire logic            cyclic_control_mapped,
    input  wire cyclic_control_t cyclic_control_object,
    // parameter object settings
    input  wire logic            param_disable_auto_ranging,
    input  wire logic [7:0]      param_mode,
    input  wire logic [7:0]      param_range,
    // converter samples, scaled to one microvolt or microampere per step
    input  wire sample_t         sample,
    // converter steering
    output logic [7:0]           mode_q,
    output logic [7:0]           range_q,
    // report to the master
    output logic signed [31:0]   measured_value_q,
    output logic                 input_update_toggle_q,
    output logic                 autorange_disabled_q
);

    // ************************************************************
    // source selection
    // ************************************************************
    // cyclic control wins while mapped; parameters act only once it is removed
    logic       manual_d;
    logic [7:0] mode_d;
    logic [7:0] manual_range_d;
    logic       stable;
    logic [7:0] stable_range;
    logic       mode_change;

    always_comb begin
        // RL3 parameter path
        if (cyclic_control_mapped) begin
            manual_d       = cyclic_control_object.disable_auto_ranging_flag;
            mode_d         = cyclic_control_object.control_mode_field;
            manual_range_d = cyclic_control_object.control_range_field;
        end else begin
            manual_d       = param_disable_auto_ranging;
            mode_d         = param_mode;
            manual_range_d = param_range;
        end
    end

    assign mode_change = (mode_d != mode_q);

    // ************************************************************
    // mode register
    // ************************************************************
    // RL1 reset mode
    // RL4 mode zero is dc voltage
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // RL1 autorange active after reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            autorange_disabled_q <= 1'b0;
        end else begin
            autorange_disabled_q <= manual_d;
        end
    end

    // ************************************************************
    // autorange decision
    // ************************************************************
    // RL7 eight samples in one range
    range_stability #(
        .NEEDED       (NEEDED)
    ) u_stability (
        .mclk         (mclk),
        .rstn         (rstn),
        .sample_valid (sample.valid),
        .sample_range (sample.range),
        .restart      (mode_change | manual_d),
        .stable       (stable),
        .stable_range (stable_range)
    );

    // ************************************************************
    // effective range
    // ************************************************************
    // a mode change keeps the old range until autorange decides again
    // three ways the range register can move on the next edge
    typedef enum logic [1:0] {
        SEL_HOLD,
        SEL_MANUAL,
        SEL_AUTO
    } range_sel_t;

    // decision signals shared by the range and value registers
    range_sel_t         range_sel;
    logic               publish;
    logic [7:0]         range_d;
    logic signed [31:0] value_d;
    logic               toggle_d;

    // ************************************************************
    // publish decision
    // ************************************************************
    // a sample counts only when the range behind it is settled
    always_comb begin
        publish = 1'b0;
        if (sample.valid) begin
            if (manual_d) begin
                // RL2 fixed range decided
                publish = 1'b1;
            end else if (stable) begin
                // RL7 eight equal samples
                publish = 1'b1;
            end else begin
                // RL8 no decision yet
                publish = 1'b0;
            end
        end
    end

    // ************************************************************
    // range selection
    // ************************************************************
    // the auto range moves only with a published sample, never ahead of the value
    always_comb begin
        if (manual_d) begin
            range_sel = SEL_MANUAL;
        end else if (publish) begin
            range_sel = SEL_AUTO;
        end else begin
            range_sel = SEL_HOLD;
        end
    end

    // next range for each selection
    always_comb begin
        case (range_sel)
            SEL_MANUAL: begin
                // RL2 manual range applies
                range_d = manual_range_d;
            end
            SEL_AUTO: begin
                // RL10 control range ignored
                range_d = stable_range;
            end
            SEL_HOLD: begin
                range_d = range_q;
            end
            default: begin
                range_d = range_q;
            end
        endcase
    end

    // ************************************************************
    // range register
    // ************************************************************
    // RL6 report range in effect
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            range_q <= RANGE_RESET;
        end else begin
            range_q <= range_d;
        end
    end

    // ************************************************************
    // next value and toggle
    // ************************************************************
    // a frozen sample leaves both outputs exactly as the master last saw them
    always_comb begin
        value_d  = measured_value_q;
        toggle_d = input_update_toggle_q;
        if (publish) begin
            // RL5 signed microunit value
            value_d  = signed'(sample.value);   // no rescaling, steps arrive in microunits
            toggle_d = ~input_update_toggle_q;
        end
    end

    // ************************************************************
    // measured value register
    // ************************************************************
    // RL8 freeze without decision
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            measured_value_q <= VALUE_RESET;
        end else begin
            measured_value_q <= value_d;
        end
    end

    // ************************************************************
    // update toggle register
    // ************************************************************
    // RL8 toggle kept while frozen
    // the master can only tell a new value from a frozen one by this bit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            input_update_toggle_q <= 1'b0;
        end else begin
            input_update_toggle_q <= toggle_d;
        end
    end

endmodule : mm_range_ctrl

// ### mm_master_model.sv
// fieldbus master model feeding cyclic control or parameter settings
module mm_master_model
    import mm_range_pkg::*;
(
    input  wire logic        mclk, rstn, use_param, dis,
    input  wire logic [7:0]  mode, rng,
    output cyclic_control_t  ctl,
    output logic             mapped, pdis,
    output logic [7:0]       pmode, prng
);
    // the path not in use keeps changing, so a wrong selection shows up
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mapped <= 1'b1;
            ctl <= '0;
            {pdis, pmode, prng} <= '0;
        end else if (use_param) begin
            mapped <= 1'b0;
            ctl <= ~ctl;
            {pdis, pmode, prng} <= {dis, mode, rng};
        end else begin
            mapped <= 1'b1;
            ctl <= {dis, mode, rng};
            {pdis, pmode, prng} <= ~{pdis, pmode, prng};
        end
    end
endmodule : mm_master_model

// ### mm_range_ctrl_checker.sv
// port checker of the multimeter mode and range control
module mm_range_ctrl_checker
    import mm_range_pkg::*;
#(parameter int NEEDED = STABLE_COUNT) (
    input wire logic mclk, rstn, cyclic_control_mapped, param_disable_auto_ranging,
    input wire cyclic_control_t cyclic_control_object,
    input wire logic [7:0] param_mode, param_range, mode_q, range_q,
    input wire sample_t sample,
    input wire logic signed [31:0] measured_value_q,
    input wire logic input_update_toggle_q, autorange_disabled_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic dis, a_s;
    logic [7:0] md, rg, last_q;
    logic [3:0] cnt_q;
    // effective control as the selected path presents it
    assign dis = cyclic_control_mapped ? cyclic_control_object.disable_auto_ranging_flag
                                       : param_disable_auto_ranging;
    assign md = cyclic_control_mapped ? cyclic_control_object.control_mode_field : param_mode;
    assign rg = cyclic_control_mapped ? cyclic_control_object.control_range_field : param_range;
    assign a_s = sample.valid && !dis && !autorange_disabled_q;
    // run of equal ranges, saturating so it never wraps
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            last_q <= '0;
        end else if (dis || md != mode_q) cnt_q <= '0;
        else if (sample.valid) begin
            last_q <= sample.range;
            cnt_q <= (sample.range != last_q || cnt_q == 0) ? 4'h1
                   : (cnt_q < 4'(NEEDED)) ? cnt_q + 4'h1 : cnt_q;
        end
    end
    property p_reset; $rose(rstn) |-> mode_q == MODE_RESET && !input_update_toggle_q; endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_mode0; md == MODE_DC_VOLT |=> mode_q == MODE_DC_VOLT; endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 not taken");
    property p_flag; dis ##1 dis |-> autorange_disabled_q; endproperty
    a_flag: assert property (p_flag) else $error("disable flag lost");
    property p_manual; dis ##1 dis |=> range_q == $past(rg); endproperty
    a_manual: assert property (p_manual) else $error("manual range not applied");
    property p_hold; !dis && !autorange_disabled_q && !sample.valid |=> $stable(range_q); endproperty
    a_hold: assert property (p_hold) else $error("range moved in auto");
    property p_freeze; a_s && cnt_q < NEEDED |=> $stable(input_update_toggle_q)
        && $stable(measured_value_q); endproperty
    a_freeze: assert property (p_freeze) else $error("value not frozen");
    property p_commit; a_s && cnt_q >= NEEDED |=> input_update_toggle_q
        != $past(input_update_toggle_q) && range_q == $past(last_q); endproperty
    a_commit: assert property (p_commit) else $error("decision not published");
    property p_value; sample.valid && dis && autorange_disabled_q
        |=> measured_value_q == $past(sample.value); endproperty
    a_value: assert property (p_value) else $error("scaled value wrong");
    property p_code1; a_s && cnt_q >= NEEDED && last_q == RANGE_30V
        |=> range_q == 8'h01; endproperty
    a_code1: assert property (p_code1) else $error("range code wrong");
    c_commit: cover property (a_s && cnt_q >= NEEDED);
    c_manual: cover property (sample.valid && dis);
    c_param: cover property (!cyclic_control_mapped && sample.valid);
endmodule : mm_range_ctrl_checker
bind mm_range_ctrl mm_range_ctrl_checker #(.NEEDED(NEEDED)) chk (.mclk, .rstn,
    .cyclic_control_mapped, .param_disable_auto_ranging, .cyclic_control_object, .param_mode,
    .param_range, .mode_q, .range_q, .sample, .measured_value_q, .input_update_toggle_q,
    .autorange_disabled_q);

// ### multimeter_mode_range_control_test.sv
// self-checking bench of the multimeter mode and range control
module multimeter_mode_range_control_test
    import mm_range_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rstn = 0, use_param = 0, dis = 0, mapped, pdis, tog_q, adis_q, ptog = 0;
    logic [7:0] mode = '0, rng = '0, pmode, prng, mode_q, range_q;
    logic signed [31:0] val_q;
    logic [31:0] seed = 32'h0001_2F5A;
    logic [39:0] e, exp_q[$];
    logic [7:0] codes [4] = '{RANGE_300MV, RANGE_3V, RANGE_30V, RANGE_300V};
    sample_t sample = '0;
    cyclic_control_t ctl;
    int fails = 0, checked = 0;
    mm_master_model MASTER (.mclk, .rstn, .use_param, .dis, .mode, .rng, .ctl, .mapped,
                            .pdis, .pmode, .prng);
    mm_range_ctrl DUT (.mclk, .rstn, .cyclic_control_mapped(mapped), .cyclic_control_object(ctl),
        .param_disable_auto_ranging(pdis), .param_mode(pmode), .param_range(prng), .sample,
        .mode_q, .range_q, .measured_value_q(val_q), .input_update_toggle_q(tog_q),
        .autorange_disabled_q(adis_q));
    initial forever #50 mclk = ~mclk;
    function logic [31:0] rnd();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task chk(string what, logic [31:0] seen, logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    task report_and_stop();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // inputs move a fixed 5 ns after the edge, away from sampling
    task idle(int n);
        sample.valid <= 1'b0;
        repeat (n) @(posedge mclk);
        #5;
    endtask : idle
    // one sample held for one edge; published ones are noted with the range to be shown
    task smp(logic [7:0] r, logic pub, logic [7:0] shown);
        logic [31:0] v;
        v = rnd();
        sample <= {1'b1, r, v};
        if (pub) exp_q.push_back({shown, v});
        @(posedge mclk);
        #5;
    endtask : smp
    // every toggle flip must match the oldest note
    initial forever begin
        @(posedge mclk);
        #1;
        if (tog_q !== ptog) begin
            ptog = tog_q;
            if (exp_q.size() == 0) chk("spurious update", 1, 0);
            else begin
                e = exp_q.pop_front();
                chk("range", {24'h0, range_q}, {24'h0, e[39:32]});
                chk("value", val_q, e[31:0]);
            end
        end
    end
    initial begin
        idle(2);
        rstn <= 1'b1;
        idle(1);
        chk("reset mode", {24'h0, mode_q}, {24'h0, MODE_RESET});
        chk("reset range", {24'h0, range_q}, {24'h0, RANGE_RESET});
        for (int i = 0; i < 9; i++) smp(RANGE_30V, i == 8, RANGE_30V);
        // the first new-range sample goes out under the committed range
        for (int i = 0; i < 10; i++) smp(i[0] ? RANGE_30V : RANGE_3V, i == 0, RANGE_30V);
        rng <= RANGE_300V;
        idle(4);
        chk("auto range", {24'h0, range_q}, {24'h0, RANGE_30V});
        $display("test auto done");
        dis <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            mode <= 8'(i);
            rng <= codes[i];
            idle(4);
            chk("mode", {24'h0, mode_q}, i);
            chk("manual flag", {31'h0, adis_q}, 1);
            smp(codes[i], 1'b1, codes[i]);
        end
        use_param <= 1'b1;
        mode <= MODE_DC_VOLT;
        rng <= RANGE_30V;
        idle(4);
        smp(RANGE_30V, 1'b1, RANGE_30V);
        idle(3);
        $display("test manual done");
        report_and_stop();
    end
    initial begin
        #1_000_000;
        fails++;
        report_and_stop();
    end
endmodule : multimeter_mode_range_control_test
